//--- design/subtract_with_borrow_op_swap_tas_pkg.sv
// Package with types and constants for the three-instruction execute unit.
package subtract_with_borrow_op_swap_tas_pkg;

    localparam int         WORD_W      = 16;
    localparam int         BYTE_W      = 8;
    localparam int         TAS_BIT     = 7;
    localparam int         FLAG_N      = 3;
    localparam int         FLAG_Z      = 2;
    localparam int         FLAG_V      = 1;
    localparam int         FLAG_C      = 0;
    localparam logic [3:0] FLAGS_RST   = 4'h0;
    localparam logic [15:0] WORD_RST   = 16'h0000;

    typedef enum logic [1:0] {
        OP_SUBTRACT_WITH_BORROW_OP = 2'h0,
        OP_SWAP = 2'h1,
        OP_TAS  = 2'h2
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_DONE  = 4'h8
    } tas_state_t;

    typedef struct packed {
        logic [15:0] data;
        logic        byte_sz;
    } operand_t;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_t;

endpackage : subtract_with_borrow_op_swap_tas_pkg

//--- design/subtract_with_borrow_op_borrow_sub.sv
// Combinational subtract with borrow at byte or word width.
`timescale 1ns/1ps
module subtract_with_borrow_op_borrow_sub
    import subtract_with_borrow_op_swap_tas_pkg::*;
(
    // Operands
    input  wire logic [15:0] minuend,
    input  wire logic [15:0] subtrahend,
    input  wire logic        borrow_in,
    input  wire logic        byte_sz,
    // Result
    output logic      [15:0] diff,
    output flags_t           flags
);
    logic [16:0] wide;
    logic [8:0]  narrow;

    always_comb begin
        wide   = {1'b0, minuend} - {1'b0, subtrahend} - {16'h0000, borrow_in};
        narrow = {1'b0, minuend[7:0]} - {1'b0, subtrahend[7:0]}
                 - {8'h00, borrow_in};
        if (byte_sz) begin
            // Upper byte of the destination is kept in byte mode.
            diff    = {minuend[15:8], narrow[7:0]};
            flags.n = narrow[7];
            flags.z = (narrow[7:0] == 8'h00);
            flags.v = (minuend[7] != subtrahend[7])
                      && (narrow[7] != minuend[7]);
            flags.c = narrow[8];
        end else begin
            diff    = wide[15:0];
            flags.n = wide[15];
            flags.z = (wide[15:0] == 16'h0000);
            flags.v = (minuend[15] != subtrahend[15])
                      && (wide[15] != minuend[15]);
            flags.c = wide[16];
        end
    end
endmodule : subtract_with_borrow_op_borrow_sub

//--- design/subtract_with_borrow_op_swap_tas_execute.sv
// Execute unit for subtract with borrow, byte swap and test-and-set.
`timescale 1ns/1ps
//
// Contract
// - Subtract writes destination minus source minus carry to the destination.
// - Subtract sets N and Z from the result, V on overflow and C on borrow.
// - Byte swap exchanges the high and low bytes of the destination.
// - Byte swap sets N and Z from the result, clears V and keeps C.
// - Test-and-set sets N and Z from the byte operand before modification.
// - Test-and-set always clears V and C.
// - Test-and-set writes a one into bit 7 of its byte operand.
// - Memory test-and-set locks bus, blocks interrupts, defers read faults.
module subtract_with_borrow_op_swap_tas_execute
    import subtract_with_borrow_op_swap_tas_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Operation request
    input  wire logic        START,
    input  wire op_t         OP,
    input  wire operand_t    DST,
    input  wire operand_t    SRC,
    input  wire logic        TAS_MEM,
    input  wire flags_t      FLAGS_IN,
    // Memory side of test-and-set
    input  wire logic        MEM_ACK,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic        MEM_ERR,
    // Results
    output logic [15:0]      RESULT,
    output flags_t           FLAGS_OUT,
    output logic             DONE,
    output logic             MEM_RD,
    output logic             MEM_WR,
    output logic [7:0]       MEM_WDATA,
    output logic             BUS_LOCK,
    output logic             IRQ_BLOCK,
    output logic             EXC_PEND
);
    tas_state_t  state_ff;
    tas_state_t  nxt_state;
    logic [15:0] sub_diff;
    flags_t      sub_flags;
    logic        err_ff;
    logic [7:0]  rd_byte_ff;

    subtract_with_borrow_op_borrow_sub u_sub (
        .minuend    (DST.data),
        .subtrahend (SRC.data),
        .borrow_in  (FLAGS_IN.c),
        .byte_sz    (DST.byte_sz),
        .diff       (sub_diff),
        .flags      (sub_flags)
    );

    wire logic start_mem = START && (OP == OP_TAS) && TAS_MEM
                           && (state_ff == ST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  if (start_mem) nxt_state = ST_READ;
            ST_READ:  if (MEM_ACK) nxt_state = ST_WRITE;
            ST_WRITE: if (MEM_ACK) nxt_state = ST_DONE;
            ST_DONE:  nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Memory control: read, then write with bit 7 set, lock held between.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MEM_RD     <= 1'b0;
            MEM_WR     <= 1'b0;
            MEM_WDATA  <= 8'h00;
            BUS_LOCK   <= 1'b0;
            IRQ_BLOCK  <= 1'b0;
            rd_byte_ff <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    MEM_RD    <= start_mem;
                    BUS_LOCK  <= start_mem;
                    IRQ_BLOCK <= start_mem;
                end
                ST_READ: if (MEM_ACK) begin
                    MEM_RD     <= 1'b0;
                    MEM_WR     <= 1'b1;
                    rd_byte_ff <= MEM_RDATA;
                    MEM_WDATA  <= MEM_RDATA | 8'h80;
                end
                ST_WRITE: if (MEM_ACK) begin
                    MEM_WR    <= 1'b0;
                    BUS_LOCK  <= 1'b0;
                    IRQ_BLOCK <= 1'b0;
                end
                default: begin
                    MEM_RD <= 1'b0;
                    MEM_WR <= 1'b0;
                end
            endcase
        end
    end

    // A read-cycle exception is held until the write has finished.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            err_ff   <= 1'b0;
            EXC_PEND <= 1'b0;
        end else begin
            EXC_PEND <= 1'b0;
            if (state_ff == ST_READ && MEM_ACK && MEM_ERR) begin
                err_ff <= 1'b1;
            end else if (state_ff == ST_DONE) begin
                err_ff   <= 1'b0;
                EXC_PEND <= err_ff;
            end
        end
    end

    // Result and flag write-back.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RESULT    <= WORD_RST;
            FLAGS_OUT <= FLAGS_RST;
            DONE      <= 1'b0;
        end else begin
            DONE <= 1'b0;
            if (state_ff == ST_DONE) begin
                RESULT      <= {8'h00, rd_byte_ff | 8'h80};
                FLAGS_OUT.n <= rd_byte_ff[TAS_BIT];
                FLAGS_OUT.z <= (rd_byte_ff == 8'h00);
                FLAGS_OUT.v <= 1'b0;
                FLAGS_OUT.c <= 1'b0;
                DONE        <= 1'b1;
            end else if (START && state_ff == ST_IDLE) begin
                case (OP)
                    OP_SUBTRACT_WITH_BORROW_OP: begin
                        RESULT    <= sub_diff;
                        FLAGS_OUT <= sub_flags;
                        DONE      <= 1'b1;
                    end
                    OP_SWAP: begin
                        RESULT      <= {DST.data[7:0], DST.data[15:8]};
                        FLAGS_OUT.n <= DST.data[7];
                        FLAGS_OUT.z <= (DST.data == 16'h0000);
                        FLAGS_OUT.v <= 1'b0;
                        FLAGS_OUT.c <= FLAGS_IN.c;
                        DONE        <= 1'b1;
                    end
                    OP_TAS: if (!TAS_MEM) begin
                        RESULT      <= {DST.data[15:8],
                                        DST.data[7:0] | 8'h80};
                        FLAGS_OUT.n <= DST.data[TAS_BIT];
                        FLAGS_OUT.z <= (DST.data[7:0] == 8'h00);
                        FLAGS_OUT.v <= 1'b0;
                        FLAGS_OUT.c <= 1'b0;
                        DONE        <= 1'b1;
                    end
                    default: DONE <= 1'b0;
                endcase
            end
        end
    end

    a_swap_bytes: assert property (@(posedge CLK) disable iff (!RST_N)
        START && state_ff == ST_IDLE && OP == OP_SWAP
        |=> RESULT == {$past(DST.data[7:0]), $past(DST.data[15:8])})
        else $error("swap result wrong");
    a_swap_flags: assert property (@(posedge CLK) disable iff (!RST_N)
        START && state_ff == ST_IDLE && OP == OP_SWAP
        |=> !FLAGS_OUT.v && FLAGS_OUT.c == $past(FLAGS_IN.c))
        else $error("swap flags wrong");
    a_subtract_with_borrow_op_value: assert property (@(posedge CLK) disable iff (!RST_N)
        START && state_ff == ST_IDLE && OP == OP_SUBTRACT_WITH_BORROW_OP && !DST.byte_sz
        |=> RESULT == 16'($past(DST.data) - $past(SRC.data)
                          - 16'($past(FLAGS_IN.c))))
        else $error("subtract result wrong");
    a_subtract_with_borrow_op_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        START && state_ff == ST_IDLE && OP == OP_SUBTRACT_WITH_BORROW_OP && !DST.byte_sz
        |=> FLAGS_OUT.z == (RESULT == 16'h0000))
        else $error("subtract zero flag wrong");
    a_subtract_with_borrow_op_byte: assert property (@(posedge CLK) disable iff (!RST_N)
        START && state_ff == ST_IDLE && OP == OP_SUBTRACT_WITH_BORROW_OP && DST.byte_sz
        |=> FLAGS_OUT.n == RESULT[7]
            && RESULT[15:8] == $past(DST.data[15:8]))
        else $error("byte subtract wrong");
    a_tas_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        state_ff == ST_DONE |=> DONE && !FLAGS_OUT.v && !FLAGS_OUT.c)
        else $error("tas did not clear V and C");
    a_tas_setbit: assert property (@(posedge CLK) disable iff (!RST_N)
        MEM_WR |-> MEM_WDATA[7])
        else $error("tas write lacks bit 7");
    a_tas_test: assert property (@(posedge CLK) disable iff (!RST_N)
        state_ff == ST_READ && MEM_ACK
        ##1 state_ff == ST_WRITE && MEM_ACK
        |=> ##1 FLAGS_OUT.n == $past(rd_byte_ff[7], 2))
        else $error("tas negative flag wrong");
    a_lock_held: assert property (@(posedge CLK) disable iff (!RST_N)
        MEM_RD ##1 MEM_WR |-> BUS_LOCK && IRQ_BLOCK)
        else $error("lock dropped inside rmw");
    a_exc_defer: assert property (@(posedge CLK) disable iff (!RST_N)
        EXC_PEND |-> !MEM_RD && !MEM_WR && $past(state_ff) == ST_DONE)
        else $error("exception not deferred");

    c_subtract_with_borrow_op: cover property (@(posedge CLK) START && OP == OP_SUBTRACT_WITH_BORROW_OP);
    c_swap: cover property (@(posedge CLK) START && OP == OP_SWAP);
    c_tas_mem: cover property (@(posedge CLK) MEM_RD ##[1:8] MEM_WR);
    c_exc: cover property (@(posedge CLK) EXC_PEND);
endmodule : subtract_with_borrow_op_swap_tas_execute

//--- verification/test_subtract_with_borrow_op_swap_tas_execute.sv
// Self-checking testbench for the subtract, swap and test-and-set unit.
`timescale 1ns/1ps
module test_subtract_with_borrow_op_swap_tas_execute
    import subtract_with_borrow_op_swap_tas_pkg::*;
;
    logic        CLK;
    logic        RST_N;
    logic        START;
    op_t         OP;
    operand_t    DST;
    operand_t    SRC;
    logic        TAS_MEM;
    flags_t      FLAGS_IN;
    logic        MEM_ACK;
    logic [7:0]  MEM_RDATA;
    logic        MEM_ERR;
    logic [15:0] RESULT;
    flags_t      FLAGS_OUT;
    logic        DONE;
    logic        MEM_RD;
    logic        MEM_WR;
    logic [7:0]  MEM_WDATA;
    logic        BUS_LOCK;
    logic        IRQ_BLOCK;
    logic        EXC_PEND;
    int          n_fail = 0;
    int          check_count = 0;

    subtract_with_borrow_op_swap_tas_execute dut (.CLK(CLK), .RST_N(RST_N), .START(START),
        .OP(OP), .DST(DST), .SRC(SRC), .TAS_MEM(TAS_MEM),
        .FLAGS_IN(FLAGS_IN), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
        .MEM_ERR(MEM_ERR), .RESULT(RESULT), .FLAGS_OUT(FLAGS_OUT),
        .DONE(DONE), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
        .MEM_WDATA(MEM_WDATA), .BUS_LOCK(BUS_LOCK),
        .IRQ_BLOCK(IRQ_BLOCK), .EXC_PEND(EXC_PEND));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // Reference for subtract with borrow; returns {n,z,v,c,result}.
    function automatic logic [19:0] subtract_with_borrow_op_ref(logic [15:0] d,
            logic [15:0] s, logic c, logic b);
        logic [16:0] w;
        logic [8:0]  y;
        w = {1'b0, d} - {1'b0, s} - {16'h0000, c};
        y = {1'b0, d[7:0]} - {1'b0, s[7:0]} - {8'h00, c};
        if (b) return {y[7], y[7:0] == 8'h00,
            (d[7] != s[7]) && (y[7] != d[7]), y[8], d[15:8], y[7:0]};
        return {w[15], w[15:0] == 16'h0000,
            (d[15] != s[15]) && (w[15] != d[15]), w[16], w[15:0]};
    endfunction : subtract_with_borrow_op_ref

    // Issues one register operation; START stays high for back-to-back use.
    task automatic reg_op(input op_t op, input logic [15:0] d, s,
            input logic b, input logic [3:0] f, input logic [15:0] er,
            input logic [3:0] ef);
        START = 1'b1;
        OP = op;
        DST = {d, b};
        SRC = {s, 1'b0};
        TAS_MEM = 1'b0;
        FLAGS_IN = f;
        @(negedge CLK);
        chk({15'h0000, DONE}, 16'h0001);
        chk(RESULT, er);
        chk({12'h000, FLAGS_OUT}, {12'h000, ef});
    endtask : reg_op

    task automatic sub_case(input logic [15:0] d, s, input logic c, b);
        logic [19:0] e;
        e = subtract_with_borrow_op_ref(d, s, c, b);
        reg_op(OP_SUBTRACT_WITH_BORROW_OP, d, s, b, {3'h5, c}, e[15:0], e[19:16]);
    endtask : sub_case

    task automatic t_register_ops;
        sub_case(16'h0005, 16'h0003, 1'b1, 1'b0);
        sub_case(16'h0000, 16'h0000, 1'b1, 1'b0);
        sub_case(16'h8000, 16'h0001, 1'b0, 1'b0);
        sub_case(16'h0003, 16'h0002, 1'b1, 1'b0);
        sub_case(16'h1280, 16'h0001, 1'b0, 1'b1);
        sub_case(16'hAB00, 16'h0000, 1'b1, 1'b1);
        reg_op(OP_SWAP, 16'h1234, 16'h0000, 1'b0, 4'h3, 16'h3412, 4'h1);
        reg_op(OP_SWAP, 16'h8180, 16'h0000, 1'b0, 4'h6, 16'h8081, 4'h8);
        reg_op(OP_SWAP, 16'h0000, 16'h0000, 1'b0, 4'hB, 16'h0000, 4'h5);
        reg_op(OP_TAS, 16'h0000, 16'h0000, 1'b0, 4'h3, 16'h0080, 4'h4);
        reg_op(OP_TAS, 16'h0080, 16'h0000, 1'b0, 4'h7, 16'h0080, 4'h8);
        reg_op(OP_TAS, 16'h0041, 16'h0000, 1'b0, 4'hF, 16'h00C1, 4'h0);
        START = 1'b0;
        @(negedge CLK);
        chk({15'h0000, DONE}, 16'h0000);
    endtask : t_register_ops

    // Memory test-and-set; a swap request is held high while it is busy.
    task automatic t_tas_mem(input logic [7:0] rd, input logic err);
        START = 1'b1;
        OP = OP_TAS;
        TAS_MEM = 1'b1;
        @(negedge CLK);
        OP = OP_SWAP;
        chk({MEM_RD, BUS_LOCK, IRQ_BLOCK}, 16'h0007);
        MEM_ACK = 1'b1;
        MEM_RDATA = rd;
        MEM_ERR = err;
        @(negedge CLK);
        MEM_RDATA = ~rd;
        MEM_ERR = 1'b0;
        chk({MEM_RD, MEM_WR, BUS_LOCK, IRQ_BLOCK}, 16'h0007);
        chk({8'h00, MEM_WDATA}, {8'h00, rd | 8'h80});
        chk({DONE, EXC_PEND}, 16'h0000);
        @(negedge CLK);
        MEM_ACK = 1'b0;
        START = 1'b0;
        chk({MEM_WR, BUS_LOCK, IRQ_BLOCK, DONE}, 16'h0000);
        chk({DONE, EXC_PEND}, 16'h0000);
        @(negedge CLK);
        chk({DONE, EXC_PEND}, {14'h0000, 1'b1, err});
        chk(RESULT, {8'h00, rd | 8'h80});
        chk({12'h000, FLAGS_OUT},
            {12'h000, rd[7], rd == 8'h00, 2'b00});
        @(negedge CLK);
        chk({DONE, EXC_PEND}, 16'h0000);
    endtask : t_tas_mem

    initial begin
        repeat (4000) @(posedge CLK);
        n_fail++;
        give_verdict();
    end

    initial begin
        RST_N = 1'b0;
        START = 1'b0;
        OP = OP_SUBTRACT_WITH_BORROW_OP;
        DST = '0;
        SRC = '0;
        TAS_MEM = 1'b0;
        FLAGS_IN = '0;
        MEM_ACK = 1'b0;
        MEM_RDATA = 8'hA5;
        MEM_ERR = 1'b0;
        repeat (16) @(negedge CLK);
        chk({DONE, MEM_RD, MEM_WR, BUS_LOCK, EXC_PEND}, 16'h0000);
        RST_N = 1'b1;
        t_register_ops();
        t_tas_mem(8'h00, 1'b1);
        t_tas_mem(8'hC3, 1'b0);
        give_verdict();
    end
endmodule : test_subtract_with_borrow_op_swap_tas_execute
